// [rtl/ddrwl_defs.svh]
// Constants of the write leveling block: register map, fields, resets, timing
`ifndef DDRWL_DEFS_SVH
`define DDRWL_DEFS_SVH
// Core clock rate
`define DDRWL_CLK_MHZ 50
// Lane geometry
`define DDRWL_LANES 2
`define DDRWL_LANE_W 8
// Command pins
`define DDRWL_ADDR_W 14
`define DDRWL_BA_W 2
`define DDRWL_SEL_MODE_REG_1 2'h1
// Mode register 1 fields
`define DDRWL_LEVEL_EN_BIT 7
`define DDRWL_OUT_OFF_BIT 12
`define DDRWL_MODE_REG_1_RST 14'h0000
// Register byte offsets
`define DDRWL_REG_CTRL 4'h0
`define DDRWL_REG_STATUS 4'h4
`define DDRWL_REG_MODE 4'h8
// Control register fields
`define DDRWL_CTRL_W 9
`define DDRWL_TERM_W 3
`define DDRWL_CTRL_NOM_LSB 0
`define DDRWL_CTRL_PARK_LSB 3
`define DDRWL_CTRL_X16_BIT 8
`define DDRWL_CTRL_RST 9'h111
// Status register fields
`define DDRWL_ST_LEVEL_BIT 0
`define DDRWL_ST_OFF_BIT 1
`define DDRWL_ST_UNDEF_BIT 2
`define DDRWL_ST_ILLEGAL_BIT 3
`define DDRWL_ST_FB_LSB 4
// Timing defaults
`define DDRWL_MOD_NCK 24
`define DDRWL_FB_DELAY_NS 100
`endif

// [rtl/ddrwl_pkg.sv]
// Types shared by the write leveling block
package ddrwl_pkg;
	// Leveling sequence states
	typedef enum logic [1:0] {
		DDRWL_ST_NORMAL,
		DDRWL_ST_LEVEL,
		DDRWL_ST_EXIT
	} ddrwl_state_t;
	// Termination code
	typedef logic [2:0] ddrwl_term_t;
endpackage

// [rtl/ddrwl_lane_if.sv]
// Carrier between the top and one byte lane sampler
`timescale 1ns/1ps
`default_nettype none
interface ddrwl_lane_if;
	logic dqs_s;
	logic ck_s;
	logic clear;
	logic rise;
	logic fb;
	modport top (output dqs_s, output ck_s, output clear, input rise, input fb);
	modport lane (input dqs_s, input ck_s, input clear, output rise, output fb);
endinterface // ddrwl_lane_if
`default_nettype wire

// [rtl/ddrwl_sync.sv]
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module ddrwl_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// Data
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] meta;
	logic [W-1:0] next_meta;
	logic [W-1:0] next_q;

	// Next stage values
	always_comb begin
		next_meta = d_i;
		next_q = meta;
	end

	// Stage registers
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			meta <= '0;
			q_o <= '0;
		end else begin
			meta <= next_meta;
			q_o <= next_q;
		end
	end
endmodule // ddrwl_sync
`default_nettype wire

// [rtl/ddrwl_lane.sv]
// One byte lane: samples CK on each rising strobe while clear is low and holds the result until clear
`timescale 1ns/1ps
`default_nettype none
module ddrwl_lane (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// Lane carrier
	ddrwl_lane_if.lane lif
);
	logic dqs_d;
	logic fb;
	logic rise;
	logic next_dqs_d;
	logic next_fb;
	logic next_rise;

	assign lif.fb = fb;
	assign lif.rise = rise;

	// Strobe edge and feedback value
	always_comb begin
		next_dqs_d = lif.dqs_s;
		next_rise = lif.dqs_s & ~dqs_d;
		next_fb = fb;
		if (lif.clear) begin
			next_fb = 1'b0;
		end else if (next_rise) begin
			next_fb = lif.ck_s;
		end
	end

	// Lane registers
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			dqs_d <= 1'b0;
			fb <= 1'b0;
			rise <= 1'b0;
		end else begin
			dqs_d <= next_dqs_d;
			fb <= next_fb;
			rise <= next_rise;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	fb_sample_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		rise && !$past(lif.clear) |-> fb == $past(lif.ck_s))
		else $error("lane feedback differs from sampled clock");
	fb_hold_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		!rise && !lif.clear && !$past(lif.clear) |=> $stable(fb) || rise || lif.clear)
		else $error("lane feedback changed without strobe edge");
endmodule // ddrwl_lane
`default_nettype wire

// [rtl/ddrwl_top.sv]
// Write leveling logic of the memory device with its Avalon-MM register slave
// Overview of operation
// - Mode write with level bit set enters leveling
// - Mode write with level bit clear leaves leveling
// - ODT switches strobe termination only, DQ off
// - Output off bit disables DQ buffers
// - DQ driven undefined from leveling entry
// - Exit write applies every mode field
// - Strobe termination applied before strobes driven
// - Rising strobe samples CK onto all DQ
// - DQ bit skew stays within feedback skew
// - No read strobe driven with feedback
// - Each byte lane reports its own strobe
`timescale 1ns/1ps
`default_nettype none
`include "ddrwl_defs.svh"
module ddrwl_top #(
	parameter int LANES = `DDRWL_LANES,
	parameter int LANE_W = `DDRWL_LANE_W,
	parameter int MOD_NCK = `DDRWL_MOD_NCK,
	parameter int FB_DELAY_NS = `DDRWL_FB_DELAY_NS
) (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic rst_b_i,
	// Avalon-MM register slave
	input wire logic [3:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	// Clock and command pins from the controller
	input wire logic ck_i,
	input wire logic cs_b_i,
	input wire logic ras_b_i,
	input wire logic cas_b_i,
	input wire logic we_b_i,
	input wire logic [`DDRWL_BA_W-1:0] ba_i,
	input wire logic [`DDRWL_ADDR_W-1:0] addr_i,
	input wire logic odt_i,
	// Strobe pins
	input wire logic [LANES-1:0] dqs_t_i,
	input wire logic [LANES-1:0] dqs_c_i,
	output logic [LANES-1:0] dqs_t_o,
	output logic [LANES-1:0] dqs_c_o,
	output logic [LANES-1:0] dqs_oe_o,
	// Data pins and termination
	output logic [LANES*LANE_W-1:0] dq_o,
	output logic [LANES*LANE_W-1:0] dq_oe_o,
	output ddrwl_pkg::ddrwl_term_t dqs_term_o,
	output ddrwl_pkg::ddrwl_term_t dq_term_o
);
	localparam int SW = 8 + `DDRWL_ADDR_W + 2 * LANES;
	localparam int MW = $clog2(MOD_NCK + 1);
	localparam int FB_RAW = FB_DELAY_NS * `DDRWL_CLK_MHZ / 1000;
	localparam int FB_CYC = (FB_RAW < 1) ? 1 : FB_RAW;

	////////////////////////////////////////////////////////////////////////
	// Reset release and pin synchronisers
	logic rst_q1;
	logic rst_b;
	logic [SW-1:0] pins_s;
	logic ck_s, cs_s, ras_s, cas_s, we_s, odt_s;
	logic [`DDRWL_BA_W-1:0] ba_s;
	logic [`DDRWL_ADDR_W-1:0] addr_s;
	logic [LANES-1:0] dqs_t_s;
	logic [LANES-1:0] dqs_c_s;

	// Reset release pipeline
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rst_q1 <= 1'b0;
			rst_b <= 1'b0;
		end else begin
			rst_q1 <= 1'b1;
			rst_b <= rst_q1;
		end
	end

	ddrwl_sync #(.W(SW)) u_sync (
		.clk_i(core_clk_i),
		.rst_b_i(rst_b),
		.d_i({ck_i, cs_b_i, ras_b_i, cas_b_i, we_b_i, odt_i, ba_i, addr_i, dqs_t_i, dqs_c_i}),
		.q_o(pins_s)
	);
	assign {ck_s, cs_s, ras_s, cas_s, we_s, odt_s, ba_s, addr_s, dqs_t_s, dqs_c_s} = pins_s;

	////////////////////////////////////////////////////////////////////////
	// Command decode and leveling sequence
	ddrwl_pkg::ddrwl_state_t state, next_state;
	logic ck_d, next_ck_d;
	logic [MW-1:0] mod_cnt, next_mod_cnt;
	logic [`DDRWL_ADDR_W-1:0] mode_reg_1, next_mode_reg_1;
	logic ck_rise;
	logic mode_wr;
	logic illegal_evt;
	logic [LANES-1:0] lane_fb;

	// Mode register set to register 1
	function automatic logic is_mode1_write(input logic cs, input logic ras, input logic cas,
		input logic we, input logic [`DDRWL_BA_W-1:0] ba);
		is_mode1_write = !cs && !ras && !cas && !we && (ba == `DDRWL_SEL_MODE_REG_1);
	endfunction

	assign ck_rise = ck_s & ~ck_d;
	assign mode_wr = ck_rise && is_mode1_write(cs_s, ras_s, cas_s, we_s, ba_s);
	assign illegal_evt = (state == ddrwl_pkg::DDRWL_ST_LEVEL) && ck_rise && !cs_s && !mode_wr;

	// Next sequence state
	always_comb begin
		next_ck_d = ck_s;
		next_state = state;
		next_mod_cnt = mod_cnt;
		next_mode_reg_1 = mode_reg_1;
		if (mode_wr) begin
			next_mode_reg_1 = addr_s;
		end
		case (state)
			ddrwl_pkg::DDRWL_ST_NORMAL: begin
				if (mode_wr && addr_s[`DDRWL_LEVEL_EN_BIT]) begin
					next_state = ddrwl_pkg::DDRWL_ST_LEVEL;
				end
			end
			ddrwl_pkg::DDRWL_ST_LEVEL: begin
				if (mode_wr && !addr_s[`DDRWL_LEVEL_EN_BIT]) begin
					next_state = ddrwl_pkg::DDRWL_ST_EXIT;
					next_mod_cnt = MW'(MOD_NCK);
				end
			end
			ddrwl_pkg::DDRWL_ST_EXIT: begin
				if (mode_wr && addr_s[`DDRWL_LEVEL_EN_BIT]) begin
					next_state = ddrwl_pkg::DDRWL_ST_LEVEL;
				end else if (ck_rise) begin
					if (mod_cnt <= MW'(1)) begin
						next_state = ddrwl_pkg::DDRWL_ST_NORMAL;
						next_mod_cnt = '0;
					end else begin
						next_mod_cnt = MW'(mod_cnt - MW'(1));
					end
				end
			end
			default: begin
				next_state = ddrwl_pkg::DDRWL_ST_NORMAL;
			end
		endcase
	end

	// Sequence registers
	always_ff @(posedge core_clk_i or negedge rst_b) begin
		if (!rst_b) begin
			ck_d <= 1'b0;
			state <= ddrwl_pkg::DDRWL_ST_NORMAL;
			mod_cnt <= '0;
			mode_reg_1 <= `DDRWL_MODE_REG_1_RST;
		end else begin
			ck_d <= next_ck_d;
			state <= next_state;
			mod_cnt <= next_mod_cnt;
			mode_reg_1 <= next_mode_reg_1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Byte lane samplers
	// independent lanes
	for (genvar g = 0; g < LANES; g++) begin : g_lane
		ddrwl_lane_if lif ();
		assign lif.dqs_s = dqs_t_s[g] & ~dqs_c_s[g];
		assign lif.ck_s = ck_s;
		assign lif.clear = (state == ddrwl_pkg::DDRWL_ST_NORMAL);
		assign lane_fb[g] = lif.fb;
		ddrwl_lane u_lane (
			.clk_i(core_clk_i),
			.rst_b_i(rst_b),
			.lif(lif.lane)
		);
	end

	////////////////////////////////////////////////////////////////////////
	// Register slave
	logic [`DDRWL_CTRL_W-1:0] ctrl, next_ctrl;
	logic illegal, next_illegal;
	logic [31:0] next_rdata;
	logic next_waitreq;
	logic [31:0] rd_mux;
	logic wr_take;

	// Byte offset match
	function automatic logic is_hit(input logic [3:0] a, input logic [3:0] off);
		is_hit = (a == off);
	endfunction

	assign wr_take = avs_write_i && !avs_waitrequest_o;

	// Read data selection
	always_comb begin
		rd_mux = '0;
		if (is_hit(avs_address_i, `DDRWL_REG_CTRL)) begin
			rd_mux[`DDRWL_CTRL_W-1:0] = ctrl;
		end else if (is_hit(avs_address_i, `DDRWL_REG_STATUS)) begin
			rd_mux[`DDRWL_ST_LEVEL_BIT] = (state == ddrwl_pkg::DDRWL_ST_LEVEL);
			rd_mux[`DDRWL_ST_OFF_BIT] = mode_reg_1[`DDRWL_OUT_OFF_BIT];
			rd_mux[`DDRWL_ST_UNDEF_BIT] = (state == ddrwl_pkg::DDRWL_ST_EXIT);
			rd_mux[`DDRWL_ST_ILLEGAL_BIT] = illegal;
			rd_mux[`DDRWL_ST_FB_LSB +: LANES] = lane_fb;
		end else if (is_hit(avs_address_i, `DDRWL_REG_MODE)) begin
			rd_mux[`DDRWL_ADDR_W-1:0] = mode_reg_1;
		end
	end

	// Next bus state: one wait cycle per request
	always_comb begin
		next_waitreq = !((avs_read_i || avs_write_i) && avs_waitrequest_o);
		next_rdata = avs_readdata_o;
		next_ctrl = ctrl;
		next_illegal = illegal;
		if (avs_read_i && avs_waitrequest_o) begin
			next_rdata = rd_mux;
		end
		if (wr_take && is_hit(avs_address_i, `DDRWL_REG_CTRL)) begin
			next_ctrl = avs_writedata_i[`DDRWL_CTRL_W-1:0];
		end
		if (wr_take && is_hit(avs_address_i, `DDRWL_REG_STATUS) && avs_writedata_i[`DDRWL_ST_ILLEGAL_BIT]) begin
			next_illegal = 1'b0;
		end
		// Event wins over clear
		if (illegal_evt) begin
			next_illegal = 1'b1;
		end
	end

	// Bus registers
	always_ff @(posedge core_clk_i or negedge rst_b) begin
		if (!rst_b) begin
			avs_waitrequest_o <= 1'b1;
			avs_readdata_o <= '0;
			ctrl <= `DDRWL_CTRL_RST;
			illegal <= 1'b0;
		end else begin
			avs_waitrequest_o <= next_waitreq;
			avs_readdata_o <= next_rdata;
			ctrl <= next_ctrl;
			illegal <= next_illegal;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pin drivers
	logic [LANES*LANE_W-1:0] next_dq, next_dq_oe;
	ddrwl_pkg::ddrwl_term_t next_dqs_term, next_dq_term, term_sel;
	logic lvl, drive;

	assign lvl = (state == ddrwl_pkg::DDRWL_ST_LEVEL);
	assign drive = lvl || (state == ddrwl_pkg::DDRWL_ST_EXIT);

	// Next pin values
	always_comb begin
		term_sel = odt_s ? ctrl[`DDRWL_CTRL_NOM_LSB +: `DDRWL_TERM_W] : ctrl[`DDRWL_CTRL_PARK_LSB +: `DDRWL_TERM_W];
		next_dqs_term = term_sel;
		next_dq_term = lvl ? '0 : term_sel;
		next_dq = dq_o;
		next_dq_oe = '0;
		for (int l = 0; l < LANES; l++) begin
			if (drive && !mode_reg_1[`DDRWL_OUT_OFF_BIT] && (l == 0 || ctrl[`DDRWL_CTRL_X16_BIT])) begin
				next_dq_oe[l*LANE_W +: LANE_W] = '1;
			end
			if (lvl) begin
				next_dq[l*LANE_W +: LANE_W] = {LANE_W{lane_fb[l]}};
			end
		end
	end

	// Pin registers; strobes never driven
	always_ff @(posedge core_clk_i or negedge rst_b) begin
		if (!rst_b) begin
			dq_o <= '0;
			dq_oe_o <= '0;
			dqs_term_o <= '0;
			dq_term_o <= '0;
			dqs_t_o <= '0;
			dqs_c_o <= '0;
			dqs_oe_o <= '0;
		end else begin
			dq_o <= next_dq;
			dq_oe_o <= next_dq_oe;
			dqs_term_o <= next_dqs_term;
			dq_term_o <= next_dq_term;
			dqs_t_o <= '0;
			dqs_c_o <= '0;
			dqs_oe_o <= '0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_b);

	level_entry_a: assert property (!lvl && mode_wr && addr_s[`DDRWL_LEVEL_EN_BIT] |=> lvl)
		else $error("leveling not entered");
	level_exit_a: assert property (lvl && mode_wr && !addr_s[`DDRWL_LEVEL_EN_BIT]
		|=> state == ddrwl_pkg::DDRWL_ST_EXIT && mod_cnt == MW'(MOD_NCK))
		else $error("leveling not left");
	strobe_term_a: assert property (lvl |=> dq_term_o == '0 &&
		dqs_term_o == $past(term_sel))
		else $error("wrong termination while leveling");
	out_off_a: assert property (drive && mode_reg_1[`DDRWL_OUT_OFF_BIT] |=> dq_oe_o == '0)
		else $error("outputs driven with output off set");
	undef_drive_a: assert property (drive && !mode_reg_1[`DDRWL_OUT_OFF_BIT]
		|=> dq_oe_o[LANE_W-1:0] == '1)
		else $error("lane zero not driven in leveling");
	mode_apply_a: assert property (mode_wr |=> mode_reg_1 == $past(addr_s))
		else $error("mode write not fully applied");
	fb_delay_a: assert property (lvl && $changed(lane_fb[0]) ##1 lvl
		|-> ##[0:FB_CYC] dq_o[0] == lane_fb[0])
		else $error("feedback late on data pins");
	fb_skew_a: assert property (lvl |=> dq_o[LANE_W-1:0] == '0 || dq_o[LANE_W-1:0] == '1)
		else $error("lane bits disagree");
	no_strobe_a: assert property (drive |-> dqs_oe_o == '0)
		else $error("strobe driven during feedback");
	illegal_flag_a: assert property (illegal_evt |=> illegal)
		else $error("illegal command not flagged");
	bus_answer_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
		else $error("bus answer late");

	enter_c: cover property (!lvl ##1 lvl);
	feedback_c: cover property (lvl && $rose(lane_fb[0]));
	exit_c: cover property (state == ddrwl_pkg::DDRWL_ST_EXIT ##1 state == ddrwl_pkg::DDRWL_ST_NORMAL);
endmodule // ddrwl_top
`default_nettype wire

// [verification/ddrwl_ctl_model.sv]
// Memory controller model: CK, commands, ODT and strobes
`timescale 1ns/1ps
`default_nettype none
module ddrwl_ctl_model (
	// Clock and command pins
	output logic ck_o,
	output logic [3:0] cmd_b_o,
	output logic [1:0] ba_o,
	output logic [13:0] addr_o,
	output logic odt_o,
	// Strobe pins
	output logic [1:0] dqs_t_o,
	output logic [1:0] dqs_c_o
);
	// Free running CK
	initial begin
		ck_o = 1'b0;
		forever #80 ck_o = ~ck_o;
	end
	initial begin
		cmd_b_o = 4'hF;
		ba_o = 2'h0;
		addr_o = 14'h0000;
		odt_o = 1'b0;
		dqs_t_o = 2'h0;
		dqs_c_o = 2'h3;
	end
	task automatic cmd(input logic [3:0] pins, input logic [13:0] a);
		@(negedge ck_o);
		cmd_b_o <= pins;
		ba_o <= 2'h1;
		addr_o <= a;
		@(negedge ck_o);
		cmd_b_o <= 4'hF;
		addr_o <= ~a;
	endtask
	// ODT level change away from CK rise
	task automatic set_odt(input logic v);
		@(negedge ck_o);
		odt_o <= v;
	endtask
	// one strobe edge mid CK phase
	task automatic pulse(input int lane, input logic lvl);
		if (lvl) @(posedge ck_o);
		else @(negedge ck_o);
		#40;
		dqs_t_o[lane] <= 1'b1;
		dqs_c_o[lane] <= 1'b0;
		#80;
		dqs_t_o[lane] <= 1'b0;
		dqs_c_o[lane] <= 1'b1;
	endtask
endmodule // ddrwl_ctl_model
`default_nettype wire

// [verification/ddr_write_leveling_mode_bench.sv]
// Self-checking bench of the write leveling block
`timescale 1ns/1ps
`default_nettype none
module ddr_write_leveling_mode_bench;
	logic core_clk_i;
	logic rst_b_i;
	logic [3:0] avs_address_i;
	logic avs_read_i;
	logic avs_write_i;
	logic [31:0] avs_writedata_i;
	logic [31:0] avs_readdata_o;
	logic avs_waitrequest_o;
	wire ck;
	wire odt;
	wire [3:0] cmd_b;
	wire [1:0] ba;
	wire [1:0] dqs_t;
	wire [1:0] dqs_c;
	wire [13:0] addr;
	logic [1:0] dqs_oe;
	logic [1:0] dqs_t_q;
	logic [1:0] dqs_c_q;
	logic [15:0] dq;
	logic [15:0] dq_oe;
	logic [2:0] dqs_term;
	logic [2:0] dq_term;
	logic [31:0] rd;
	int bad_count = 0;
	int check_count = 0;
	////////////////////////////////////////////////////////////////////////
	ddrwl_ctl_model ctl (.ck_o(ck), .cmd_b_o(cmd_b), .ba_o(ba), .addr_o(addr), .odt_o(odt),
		.dqs_t_o(dqs_t), .dqs_c_o(dqs_c));
	ddrwl_top #(.MOD_NCK(2)) DUT (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
		.avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
		.avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
		.avs_waitrequest_o(avs_waitrequest_o), .ck_i(ck), .cs_b_i(cmd_b[3]), .ras_b_i(cmd_b[2]),
		.cas_b_i(cmd_b[1]), .we_b_i(cmd_b[0]), .ba_i(ba), .addr_i(addr), .odt_i(odt),
		.dqs_t_i(dqs_t), .dqs_c_i(dqs_c), .dqs_t_o(dqs_t_q), .dqs_c_o(dqs_c_q), .dqs_oe_o(dqs_oe),
		.dq_o(dq), .dq_oe_o(dq_oe), .dqs_term_o(dqs_term), .dq_term_o(dq_term));
	////////////////////////////////////////////////////////////////////////
	// Core clock
	initial begin
		core_clk_i = 1'b0;
		forever #10 core_clk_i = ~core_clk_i;
	end
	// Compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count = check_count + 1;
		if (got !== exp) begin
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
			bad_count = bad_count + 1;
		end
	endtask
	// Counts and verdict
	task automatic stop_test();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// Avalon transfer, read data into rd; request held until waitrequest is sampled low
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		@(posedge core_clk_i);
		avs_address_i <= a;
		avs_writedata_i <= d;
		avs_read_i <= !w;
		avs_write_i <= w;
		for (n = 0; n < 50; n++) begin
			@(posedge core_clk_i);
			if (avs_waitrequest_o === 1'b0) begin
				rd = avs_readdata_o;
				break;
			end
		end
		// Released at the accepting edge so no second request is seen
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
		if (n == 50) begin
			bad_count = bad_count + 1;
			stop_test();
		end
	endtask
	// Poll one status bit, bounded
	task automatic wait_st(input int b, input logic v);
		int n;
		for (n = 0; n < 40; n++) begin
			bus(1'b0, 4'h4, 32'h0);
			if (rd[b] === v) break;
		end
		chk(rd[b], v);
		if (n == 40) stop_test();
	endtask
	// Let outputs settle
	task automatic settle(input int n);
		repeat (n) @(posedge core_clk_i);
		@(negedge core_clk_i);
	endtask
	////////////////////////////////////////////////////////////////////////
	// Reset values and unmapped place
	task automatic t_regs();
		bus(1'b0, 4'h0, 32'h0);
		chk(rd, 32'h0000_0111);
		bus(1'b0, 4'h4, 32'h0);
		chk(rd, 32'h0);
		bus(1'b1, 4'hC, 32'hFFFF_FFFF);
		bus(1'b0, 4'hC, 32'h0);
		chk(rd, 32'h0);
		$display("test regs done");
	endtask
	// Entry and strobe termination
	task automatic t_enter();
		bus(1'b1, 4'h0, 32'h0000_012B);
		ctl.cmd(4'h0, 14'h0080);
		wait_st(0, 1'b1);
		settle(2);
		chk(dq_oe, 16'hFFFF);
		chk(dq_term, 3'h0);
		ctl.set_odt(1'b1);
		settle(10);
		chk(dqs_term, 3'h3);
		chk(dq_term, 3'h0);
		ctl.set_odt(1'b0);
		settle(10);
		chk(dqs_term, 3'h5);
		$display("test enter done");
	endtask
	// Sweep each lane high then low, other lane must stay low
	task automatic t_fb();
		int l;
		int v;
		for (l = 0; l < 2; l++) begin
			for (v = 0; v < 2; v++) begin
				ctl.pulse(l, !v[0]);
				settle(12);
				chk(dq[8*l +: 8], {8{!v[0]}});
				chk(dq[8*(1-l) +: 8], 8'h00);
				chk({dqs_oe, dqs_t_q, dqs_c_q}, 32'h0);
			end
		end
		$display("test feedback done");
	endtask
	// Output off and back on
	task automatic t_qoff();
		ctl.cmd(4'h0, 14'h1080);
		wait_st(1, 1'b1);
		settle(2);
		chk(dq_oe, 16'h0);
		ctl.cmd(4'h0, 14'h0080);
		wait_st(1, 1'b0);
		settle(2);
		chk(dq_oe, 16'hFFFF);
		$display("test qoff done");
	endtask
	// Forbidden command flagged, not obeyed
	task automatic t_bad();
		ctl.cmd(4'h6, 14'h0000);
		wait_st(3, 1'b1);
		chk(rd[0], 1'b1);
		bus(1'b0, 4'h8, 32'h0);
		chk(rd, 32'h0080);
		bus(1'b1, 4'h4, 32'h0000_0008);
		wait_st(3, 1'b0);
		$display("test illegal done");
	endtask
	// Exit with other fields changed
	task automatic t_exit();
		ctl.cmd(4'h0, 14'h1000);
		wait_st(0, 1'b0);
		wait_st(2, 1'b0);
		bus(1'b0, 4'h8, 32'h0);
		chk(rd, 32'h1000);
		wait_st(1, 1'b1);
		settle(2);
		chk(dq_oe, 16'h0);
		chk(dq, 16'h0);
		ctl.set_odt(1'b1);
		settle(10);
		chk(dq_term, 3'h3);
		$display("test exit done");
	endtask
	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		rst_b_i = 1'b0;
		avs_address_i = 4'h0;
		avs_read_i = 1'b0;
		avs_write_i = 1'b0;
		avs_writedata_i = 32'h0;
		repeat (6) @(posedge core_clk_i);
		rst_b_i <= 1'b1;
		repeat (5) @(posedge core_clk_i);
		t_regs();
		t_enter();
		t_fb();
		t_qoff();
		t_bad();
		t_exit();
		stop_test();
	end
	// Overall hang guard
	initial begin
		#1000000;
		bad_count = bad_count + 1;
		stop_test();
	end
endmodule // ddr_write_leveling_mode_bench
`default_nettype wire
